// ===== acc_cmp_model.sv
`timescale 1ns/100ps
module acc_cmp_model (
  input  wire logic pos_gt_neg_i,
  output logic      raw_o
);
  // analog response is not instant; edges land off the clock
  initial begin
    raw_o = 1'b0;
    forever @(pos_gt_neg_i) raw_o <= #3 pos_gt_neg_i;
  end
endmodule : acc_cmp_model

// ===== acc_params.svh
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_CTRL_ADDR    8'h9B
`define ACC_MUX_ADDR     8'h9F
`define ACC_MODE_ADDR    8'h9D
`define ACC_CTRL_RST     8'h00
`define ACC_MUX_RST      8'h00
`define ACC_MODE_RST     8'h02
`define ACC_BIT_ON       7
`define ACC_BIT_LEVEL    6
`define ACC_BIT_RISE     5
`define ACC_BIT_FALL     4
`define ACC_BIT_RIE      5
`define ACC_BIT_FIE      4
`define ACC_HYS_POS_LSB  2
`define ACC_HYS_NEG_LSB  0
`define ACC_SEL_POS_LSB  0
`define ACC_SEL_NEG_LSB  4
`define ACC_RESP_LSB     0
`endif

// ===== acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_HYS_OFF = 2'h0,
    ACC_HYS_5MV = 2'h1,
    ACC_HYS_10MV = 2'h2,
    ACC_HYS_20MV = 2'h3
  } acc_hys_e;
  typedef struct packed {
    logic     comparator_on;
    acc_hys_e pos_hysteresis_sel;
    acc_hys_e neg_hysteresis_sel;
    logic [1:0] positive_input_select;
    logic [1:0] negative_input_select;
  } acc_analog_cfg_s;
endpackage : acc_pkg

// ===== acc_sync.sv
`timescale 1ns/100ps
module acc_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  wire  agree = (s2_ff == s3_ff);
  wire  nxt_lvl = agree ? s3_ff : lvl_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff  <= async_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign level_o = lvl_ff;
endmodule : acc_sync

// ===== acc_top.sv
// Notes on behaviour
// (R1) a high-to-low output change sets the fall flag
// (R2) a low-to-high output change sets the rise flag
// (R3) edge flags stay set; only a software write of zero clears them
// (R4) current output level readable at any time, read-only
// (R5) comparator runs only while the enable bit (bit 7) is one
// (R6) disabled comparator drives its pin outputs low
// (R7) negative hysteresis code: 00 off, 01 5 mV, 10 10 mV, 11 20 mV
// (R8) bits 3..2 select positive hysteresis, same code set
// (R9) one clock-registered output and one raw output usable without clock
// (R10) interrupt request on rising, falling, or both edges
// (R11) first instance offers its output as a reset source
// (R12) mux register holds two-bit positive and negative input selects
// (R13) control register resets to zero; level bit read-only, rest writable
// (R14) mode register bit 5 enables rise irq, bit 4 fall irq
// (R15) level reads one when positive input exceeds negative input
// (R16) irq = (rise flag and its enable) or (fall flag and its enable)
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_top
  import acc_pkg::*;
#(
  parameter bit IS_FIRST = 1'b1
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WR_I,
  output logic      [7:0] SFR_RDATA_O,
  input  wire logic       CMP_RAW_I,
  output acc_analog_cfg_s ANALOG_CFG_O,
  output logic            SYNC_LATCHED_OUTPUT_O,
  output logic            ASYNC_RAW_OUTPUT_O,
  output logic            IRQ_O,
  output logic            RESET_SOURCE_O
);
  localparam logic [7:0] CTRL_RST = `ACC_CTRL_RST;
  localparam logic [7:0] MUX_RST  = `ACC_MUX_RST;
  localparam logic [7:0] MODE_RST = `ACC_MODE_RST;
  // index 1 is the rising edge, index 0 the falling one, as in the registers
  localparam int         EDGES    = 2;

  logic            on_ff;
  acc_hys_e        pos_hys_ff;
  acc_hys_e        neg_hys_ff;
  logic [1:0]      pos_sel_ff;
  logic [1:0]      neg_sel_ff;
  logic [1:0]      resp_mode_ff;
  logic            level_d_ff;
  logic            latched_ff;
  logic            level;

  logic            nxt_on;
  acc_hys_e        nxt_pos_hys;
  acc_hys_e        nxt_neg_hys;
  logic [1:0]      nxt_pos_sel;
  logic [1:0]      nxt_neg_sel;
  logic [1:0]      nxt_resp_mode;
  logic            nxt_level_d;
  logic            nxt_latched;

  wire             sel_ctrl;
  wire             sel_mux;
  wire             sel_mode;
  wire             wr_ctrl;
  wire             wr_mux;
  wire             wr_mode;
  wire             comparator_on;
  wire             lvl_gated;
  wire             rise_ev;
  wire             fall_ev;
  wire [EDGES-1:0] edge_ev;
  wire [EDGES-1:0] flag_wbit;
  wire [EDGES-1:0] ien_wbit;
  wire [EDGES-1:0] flag_rst;
  wire [EDGES-1:0] ien_rst;
  wire [EDGES-1:0] flags;
  wire [EDGES-1:0] irq_en;
  wire [7:0]       rd_ctrl;
  wire [7:0]       rd_mux;
  wire [7:0]       rd_mode;

  // three-stage agreement filter on the unclocked comparator output [R15]
  acc_sync u_sync (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (CMP_RAW_I),
    .level_o (level)
  );

  assign sel_ctrl = (SFR_ADDR_I == `ACC_CTRL_ADDR);
  assign sel_mux  = (SFR_ADDR_I == `ACC_MUX_ADDR);
  assign sel_mode = (SFR_ADDR_I == `ACC_MODE_ADDR);
  assign wr_ctrl  = SFR_WR_I & sel_ctrl;
  assign wr_mux   = SFR_WR_I & sel_mux;
  assign wr_mode  = SFR_WR_I & sel_mode;

  assign comparator_on = on_ff; // [R5]
  // edges are seen on the gated level, so switching off while high counts as a fall
  assign lvl_gated     = comparator_on & level; // [R5] [R6]
  assign rise_ev       = lvl_gated & ~level_d_ff; // [R2]
  assign fall_ev       = ~lvl_gated & level_d_ff; // [R1]
  assign edge_ev       = {rise_ev, fall_ev};

  assign flag_wbit = {SFR_WDATA_I[`ACC_BIT_RISE], SFR_WDATA_I[`ACC_BIT_FALL]};
  assign ien_wbit  = {SFR_WDATA_I[`ACC_BIT_RIE], SFR_WDATA_I[`ACC_BIT_FIE]};
  assign flag_rst  = {CTRL_RST[`ACC_BIT_RISE], CTRL_RST[`ACC_BIT_FALL]};
  assign ien_rst   = {MODE_RST[`ACC_BIT_RIE], MODE_RST[`ACC_BIT_FIE]};

  assign nxt_on        = wr_ctrl ? SFR_WDATA_I[`ACC_BIT_ON] : on_ff; // [R5]
  assign nxt_pos_hys   = wr_ctrl ? acc_hys_e'(SFR_WDATA_I[`ACC_HYS_POS_LSB +: 2]) // [R8]
                                 : pos_hys_ff;
  assign nxt_neg_hys   = wr_ctrl ? acc_hys_e'(SFR_WDATA_I[`ACC_HYS_NEG_LSB +: 2]) // [R7]
                                 : neg_hys_ff;
  assign nxt_pos_sel   = wr_mux ? SFR_WDATA_I[`ACC_SEL_POS_LSB +: 2] : pos_sel_ff; // [R12]
  assign nxt_neg_sel   = wr_mux ? SFR_WDATA_I[`ACC_SEL_NEG_LSB +: 2] : neg_sel_ff; // [R12]
  // response-time code is only stored; the analog side takes it elsewhere
  assign nxt_resp_mode = wr_mode ? SFR_WDATA_I[`ACC_RESP_LSB +: 2] : resp_mode_ff;
  assign nxt_level_d   = lvl_gated;
  assign nxt_latched   = lvl_gated; // [R9] [R6]

  generate
    for (genvar g = 0; g < EDGES; g++) begin : g_edge
      logic flag_ff;
      logic ien_ff;
      logic keep_flag;
      logic nxt_flag;
      logic nxt_ien;
      // a write of zero clears; an edge in that same cycle wins [R3]
      assign keep_flag = wr_ctrl ? flag_wbit[g] : flag_ff;
      assign nxt_flag  = keep_flag | edge_ev[g]; // [R1] [R2] [R3]
      assign nxt_ien   = wr_mode ? ien_wbit[g] : ien_ff; // [R14]
      always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
          flag_ff <= flag_rst[g]; // [R13]
          ien_ff  <= ien_rst[g];
        end else begin
          flag_ff <= nxt_flag;
          ien_ff  <= nxt_ien;
        end
      end
      assign flags[g]  = flag_ff;
      assign irq_en[g] = ien_ff;
    end
  endgenerate

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      on_ff <= CTRL_RST[`ACC_BIT_ON]; // [R13]
    end else begin
      on_ff <= nxt_on;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pos_hys_ff <= acc_hys_e'(CTRL_RST[`ACC_HYS_POS_LSB +: 2]); // [R13]
    end else begin
      pos_hys_ff <= nxt_pos_hys;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      neg_hys_ff <= acc_hys_e'(CTRL_RST[`ACC_HYS_NEG_LSB +: 2]); // [R13]
    end else begin
      neg_hys_ff <= nxt_neg_hys;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pos_sel_ff <= MUX_RST[`ACC_SEL_POS_LSB +: 2];
    end else begin
      pos_sel_ff <= nxt_pos_sel;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      neg_sel_ff <= MUX_RST[`ACC_SEL_NEG_LSB +: 2];
    end else begin
      neg_sel_ff <= nxt_neg_sel;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      resp_mode_ff <= MODE_RST[`ACC_RESP_LSB +: 2];
    end else begin
      resp_mode_ff <= nxt_resp_mode;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      level_d_ff <= 1'b0;
      latched_ff <= 1'b0;
    end else begin
      level_d_ff <= nxt_level_d;
      latched_ff <= nxt_latched;
    end
  end

  // level bit is live status, never stored from a write [R4] [R13]
  assign rd_ctrl = {on_ff, lvl_gated, flags, pos_hys_ff, neg_hys_ff};
  assign rd_mux  = {2'h0, neg_sel_ff, 2'h0, pos_sel_ff}; // [R12]
  assign rd_mode = {2'h0, irq_en, 2'h0, resp_mode_ff}; // [R14]
  assign SFR_RDATA_O = sel_ctrl ? rd_ctrl :
                       sel_mux  ? rd_mux  :
                       sel_mode ? rd_mode : 8'h00;

  assign ANALOG_CFG_O = '{comparator_on:         on_ff, // [R5]
                          pos_hysteresis_sel:    pos_hys_ff, // [R8]
                          neg_hysteresis_sel:    neg_hys_ff, // [R7]
                          positive_input_select: pos_sel_ff, // [R12]
                          negative_input_select: neg_sel_ff};

  assign SYNC_LATCHED_OUTPUT_O = latched_ff; // [R9]
  // raw path is pure gating so it keeps working with the clock stopped [R9] [R6]
  assign ASYNC_RAW_OUTPUT_O    = comparator_on & CMP_RAW_I;
  assign IRQ_O                 = |(flags & irq_en); // [R10] [R16] [R14]
  assign RESET_SOURCE_O        = IS_FIRST & ~latched_ff & comparator_on; // [R11]
endmodule : acc_top

// ===== acc_top_properties.sv
`timescale 1ns/100ps
module acc_top_properties
  import acc_pkg::*;
(
  input wire logic            REF_CLK_I,
  input wire logic            RST_N_I,
  input wire logic [7:0]      SFR_ADDR_I,
  input wire logic [7:0]      SFR_WDATA_I,
  input wire logic            SFR_WR_I,
  input wire logic [7:0]      SFR_RDATA_O,
  input wire logic            CMP_RAW_I,
  input wire acc_analog_cfg_s ANALOG_CFG_O,
  input wire logic            SYNC_LATCHED_OUTPUT_O,
  input wire logic            ASYNC_RAW_OUTPUT_O,
  input wire logic            IRQ_O,
  input wire logic            RESET_SOURCE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire ctl = SFR_ADDR_I == 8'h9B;
  wire on  = ANALOG_CFG_O.comparator_on;
  a_rise_flag: assert property (ctl && $rose(SYNC_LATCHED_OUTPUT_O) |-> SFR_RDATA_O[5])
    else $error("rise flag missed");
  a_fall_flag: assert property (ctl && $fell(SYNC_LATCHED_OUTPUT_O) |-> SFR_RDATA_O[4])
    else $error("fall flag missed");
  a_flag_sticky: assert property (ctl && $past(ctl) && $past(SFR_RDATA_O[5]) &&
    !$past(SFR_WR_I) |-> SFR_RDATA_O[5]) else $error("rise flag dropped");
  a_off_low: assert property (!on [*3] |-> !SYNC_LATCHED_OUTPUT_O)
    else $error("latched output high while off");
  a_raw_gate: assert property (ASYNC_RAW_OUTPUT_O == (CMP_RAW_I & on))
    else $error("raw output wrong");
  a_enable_bit: assert property (ctl |-> SFR_RDATA_O[7] == on) else $error("enable bit");
  a_hys_fields: assert property (ctl |-> SFR_RDATA_O[3:0] ==
    {ANALOG_CFG_O.pos_hysteresis_sel, ANALOG_CFG_O.neg_hysteresis_sel}) else $error("hys");
  a_mux_unused: assert property (SFR_ADDR_I == 8'h9F |-> (SFR_RDATA_O & 8'hCC) == 8'h00)
    else $error("mux unused bits");
  a_irq_masked: assert property (SFR_ADDR_I == 8'h9D && SFR_RDATA_O[5:4] == 2'b00 |-> !IRQ_O)
    else $error("irq while masked");
  c_rise: cover property (ctl && $rose(SYNC_LATCHED_OUTPUT_O));
  c_irq: cover property (IRQ_O);
  c_ctl_write: cover property (SFR_WR_I && ctl);
endmodule : acc_top_properties
bind acc_top acc_top_properties chk (.*);

// ===== tb_acc_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_acc_top;
  logic clk = 0, rst_n = 0, wr = 0, lvl = 0, raw, sync_o, async_o, irq, rsrc, rsrc_b;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  acc_pkg::acc_analog_cfg_s cfg;
  int fail_count = 0, n_tests = 0, cyc = 0;
  acc_cmp_model far (.pos_gt_neg_i(lvl), .raw_o(raw));
  acc_top dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WDATA_I(wd),
    .SFR_WR_I(wr), .SFR_RDATA_O(rdat), .CMP_RAW_I(raw), .ANALOG_CFG_O(cfg),
    .SYNC_LATCHED_OUTPUT_O(sync_o), .ASYNC_RAW_OUTPUT_O(async_o), .IRQ_O(irq),
    .RESET_SOURCE_O(rsrc));
  acc_top #(.IS_FIRST(1'b0)) dut_b (.REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr),
    .SFR_WDATA_I(wd), .SFR_WR_I(wr), .SFR_RDATA_O(), .CMP_RAW_I(raw), .ANALOG_CFG_O(),
    .SYNC_LATCHED_OUTPUT_O(), .ASYNC_RAW_OUTPUT_O(), .IRQ_O(), .RESET_SOURCE_O(rsrc_b));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      fail_count++;
      results();
    end
  end
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    #1 addr = a;
    wd = d;
    wr = 1;
    @(posedge clk);
    #1 wr = 0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge clk);
    #1 addr = a;
    #1 `CHK($sformatf("reg %h", a), e, rdat)
  endtask : rd_chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    rd_chk(8'h55, 8'h00);
    rd_chk(8'h9F, 8'h00);
    rd_chk(8'h9D, 8'h02);
    rd_chk(8'h9B, 8'h00);
    $display("test reset done");
    wr_reg(8'h9B, 8'hC6);
    wr_reg(8'h9F, 8'hDE);
    wr_reg(8'h9D, 8'h32);
    rd_chk(8'h9F, 8'h12);
    rd_chk(8'h9D, 8'h32);
    rd_chk(8'h9B, 8'h86);
    `CHK("cfg", 9'h169, cfg)
    lvl = 1;
    repeat (8) @(posedge clk);
    rd_chk(8'h9B, 8'hE6);
    `CHK("outs", 3'b111, {sync_o, async_o, irq})
    lvl = 0;
    repeat (8) @(posedge clk);
    rd_chk(8'h9B, 8'hB6);
    wr_reg(8'h9B, 8'h96);
    rd_chk(8'h9B, 8'h96);
    `CHK("fall irq", 1'b1, irq)
    wr_reg(8'h9D, 8'h22);
    `CHK("fall masked", 1'b0, irq)
    wr_reg(8'h9B, 8'h86);
    rd_chk(8'h9B, 8'h86);
    `CHK("irq rst", 3'b010, {irq, rsrc, rsrc_b})
    $display("test edges done");
    wr_reg(8'h9B, 8'h06);
    lvl = 1;
    repeat (8) @(posedge clk);
    rd_chk(8'h9B, 8'h06);
    `CHK("off", 3'b000, {sync_o, async_o, rsrc})
    $display("test disable done");
    results();
  end
endmodule : tb_acc_top
